// File: hw/nbc_host.v
// Function
// - Send a full address (op 1) as five bytes: two column, three row, LSB first; op 2 sends two column bytes.
// - Drive unused bits in address cycles two and five to zero.
// - Cache read codes: 60h 60h 33h start, 31h next, 3Fh end.
// - Program codes: 80h, 10h confirm, 85h random in, 15h cache, 11h/81h.
// - Copy-back codes: 00h 35h read, 85h 10h program, two-plane forms.
// - Command: CS low, CLE high, ALE low, read strobe high, WE rising.
// - Hold write protect high for program or erase commands and addresses.
// - Address: CS low, ALE high, CLE low, read strobe high, WE rising.
// - Data in: CS, latches low; read strobe, WP high; WE rising.
// - Data out one byte per read strobe toggle; CS, WE, latches held.
// - Standby only after CS held high at least 10us.
// - Completion from busy pin or status bit 6; 00h leaves status mode.
// - In-order output, strobe period >= 25ns; 05h, column, E0h relocates.
`include "nbc_regs.vh"
`timescale 1ns/100ps
`default_nettype none
module nbc_host #(
   parameter CLK_NS = `NBC_CYCLE_NS,
   parameter STBY_CYC = (`NBC_STBY_US * 1000 + CLK_NS - 1) / CLK_NS,
   parameter LOAD_CYC = (`NBC_LOAD_US * 1000) / CLK_NS
) (
   input wire clk, // 125 MHz clock
   input wire nrst, // Sync reset, active low
   input wire ce, // Clock enable
   input wire cmd_valid, // Request strobe
   output wire cmd_ready, // Idle, request accepted when ce high
   input wire [1:0] cmd_op, // 0 cmd,1 addr5,2 addr2 col,3 read/write bytes
   input wire [7:0] cmd_code, // Command byte
   input wire [31:0] cmd_addr, // Column in [12:0], row in [31:13]
   input wire [12:0] cmd_len, // Byte count for op 3
   input wire cmd_write, // Op 3 writes data
   input wire cmd_modify, // Part of a program or erase
   input wire [7:0] wdata, // Write byte
   output wire wdata_take, // Pulse: wdata consumed
   output reg [7:0] rdata_q, // Read byte
   output reg rdata_valid_q, // Pulse: rdata_q new
   output reg cs_n_q, // Chip select low
   output reg cle_q, // Command latch strobe
   output reg ale_q, // Address latch strobe
   output reg write_strobe_n_q, // Write strobe
   output reg read_strobe_n_q, // Read strobe
   output reg modify_lock_n_q, // High lets modify run
   input wire [7:0] shared_io_bus_i, // IO bus in
   output reg [7:0] shared_io_bus_o_q, // IO bus out
   output reg shared_io_bus_oe_q, // IO bus drive
   input wire ready_busy_n, // Busy line, low busy
   output wire device_ready, // Device not busy
   output reg standby_q, // Device in standby
   output reg load_timeout_q // Busy past load time
);
   localparam S_IDLE = 3'd0;
   localparam S_SETUP = 3'd1;
   localparam S_LOW = 3'd2;
   localparam S_HIGH = 3'd3;
   localparam S_RLOW = 3'd4;
   localparam S_RHIGH = 3'd5;
   // Half-periods sized so a strobe pulse is never short; timer load of 2 gives 3 cycles = 24ns
   localparam [2:0] HALF = 3'd2;
   reg [2:0] st_q;
   reg [2:0] tmr_q;
   reg [2:0] idx_q;
   reg [2:0] nbytes_q;
   reg [1:0] op_q;
   reg [7:0] code_q;
   reg [31:0] addr_q;
   reg [12:0] cnt_q;
   reg wr_q;
   reg [15:0] stby_q;
   reg [15:0] busy_q;

   function [7:0] addr_byte;
      input [31:0] a;
      input [2:0] i;
      begin
         case (i)
            3'd0: addr_byte = a[7:0];
            3'd1: addr_byte = {3'b000, a[12:8]};
            3'd2: addr_byte = a[20:13];
            3'd3: addr_byte = a[28:21];
            3'd4: addr_byte = {5'b00000, a[31:29]};
            default: addr_byte = 8'h00;
         endcase
      end
   endfunction

   // Plane setup 60h also opens an erase, so only the caller can mark it
   function is_modify;
      input [7:0] c;
      begin
         case (c)
            `NBC_CMD_PROG1: is_modify = 1'b1;
            `NBC_CMD_PROG2: is_modify = 1'b1;
            `NBC_CMD_CACHE_PROG: is_modify = 1'b1;
            `NBC_CMD_PROG_PLANE2: is_modify = 1'b1;
            `NBC_CMD_RND_IN: is_modify = 1'b1;
            `NBC_CMD_DUMMY_PROG: is_modify = 1'b1;
            `NBC_CMD_ERASE2: is_modify = 1'b1;
            `NBC_CMD_COPY_READ: is_modify = 1'b0;
            `NBC_CMD_CACHE_START: is_modify = 1'b0;
            `NBC_CMD_CACHE_NEXT: is_modify = 1'b0;
            `NBC_CMD_CACHE_END: is_modify = 1'b0;
            default: is_modify = 1'b0;
         endcase
      end
   endfunction

   assign cmd_ready = (st_q == S_IDLE);
   assign device_ready = ready_busy_n;
   assign wdata_take = ce && st_q == S_SETUP && op_q == 2'd3 && wr_q;

   always @(posedge clk) begin
      if (!nrst) begin
         st_q <= S_IDLE;
         tmr_q <= 3'd0;
         idx_q <= 3'd0;
         nbytes_q <= 3'd0;
         op_q <= 2'd0;
         code_q <= 8'h00;
         addr_q <= 32'h0;
         cnt_q <= 13'd0;
         wr_q <= 1'b0;
         rdata_q <= 8'h00;
         rdata_valid_q <= 1'b0;
         cs_n_q <= 1'b1;
         cle_q <= 1'b0;
         ale_q <= 1'b0;
         write_strobe_n_q <= 1'b1;
         read_strobe_n_q <= 1'b1;
         modify_lock_n_q <= 1'b0;
         shared_io_bus_o_q <= 8'h00;
         shared_io_bus_oe_q <= 1'b0;
         stby_q <= 16'd0;
         standby_q <= 1'b0;
         busy_q <= 16'd0;
         load_timeout_q <= 1'b0;
      end else if (ce) begin
         rdata_valid_q <= 1'b0;
         // Standby tracked from our own select line
         if (!cs_n_q) begin
            stby_q <= 16'd0;
            standby_q <= 1'b0;
         end else if (stby_q >= STBY_CYC[15:0] - 16'd1) begin
            standby_q <= 1'b1;
         end else begin
            stby_q <= stby_q + 16'd1;
         end
         if (ready_busy_n) begin
            busy_q <= 16'd0;
            load_timeout_q <= 1'b0;
         end else if (busy_q >= LOAD_CYC[15:0]) begin
            load_timeout_q <= 1'b1;
         end else begin
            busy_q <= busy_q + 16'd1;
         end
         if (tmr_q != 3'd0)
            tmr_q <= tmr_q - 3'd1;
         case (st_q)
            S_IDLE: begin
               // Select dropped while no request waits; device keeps loading
               if (cmd_valid) begin
                  op_q <= cmd_op;
                  code_q <= cmd_code;
                  addr_q <= cmd_addr;
                  cnt_q <= cmd_len;
                  wr_q <= cmd_write;
                  // Known modify codes open the lock even if unflagged
                  modify_lock_n_q <= cmd_modify ||
                     (cmd_op == 2'd0 && is_modify(cmd_code));
                  idx_q <= 3'd0;
                  nbytes_q <= (cmd_op == 2'd1) ? `NBC_ADDR_CYCLES :
                     (cmd_op == 2'd2) ? 3'd2 : 3'd1;
                  cs_n_q <= 1'b0;
                  if (cmd_op == 2'd3 && cmd_len == 13'd0) begin
                     st_q <= S_IDLE;
                     cs_n_q <= 1'b1;
                  end else begin
                     st_q <= S_SETUP;
                  end
               end else begin
                  cs_n_q <= 1'b1;
               end
            end
            S_SETUP: begin
               tmr_q <= HALF;
               if (op_q == 2'd3 && !wr_q) begin
                  shared_io_bus_oe_q <= 1'b0;
                  cle_q <= 1'b0;
                  ale_q <= 1'b0;
                  read_strobe_n_q <= 1'b0;
                  st_q <= S_RLOW;
               end else begin
                  cle_q <= (op_q == 2'd0);
                  ale_q <= (op_q == 2'd1 || op_q == 2'd2);
                  shared_io_bus_oe_q <= 1'b1;
                  shared_io_bus_o_q <= (op_q == 2'd0) ? code_q :
                     (op_q == 2'd3) ? wdata : addr_byte(addr_q, idx_q);
                  write_strobe_n_q <= 1'b0;
                  st_q <= S_LOW;
               end
            end
            S_LOW: begin
               if (tmr_q == 3'd0) begin
                  write_strobe_n_q <= 1'b1; // Rising edge latches byte
                  tmr_q <= HALF;
                  st_q <= S_HIGH;
               end
            end
            S_HIGH: begin
               if (tmr_q == 3'd0) begin
                  if (op_q == 2'd3 && cnt_q != 13'd1) begin
                     cnt_q <= cnt_q - 13'd1;
                     st_q <= S_SETUP;
                  end else if (op_q != 2'd3 && idx_q + 3'd1 < nbytes_q) begin
                     idx_q <= idx_q + 3'd1;
                     st_q <= S_SETUP;
                  end else begin
                     cle_q <= 1'b0;
                     ale_q <= 1'b0;
                     shared_io_bus_oe_q <= 1'b0;
                     st_q <= S_IDLE;
                  end
               end
            end
            S_RLOW: begin
               if (tmr_q == 3'd0) begin
                  rdata_q <= shared_io_bus_i; // Sampled after access delay
                  rdata_valid_q <= 1'b1;
                  read_strobe_n_q <= 1'b1;
                  tmr_q <= HALF;
                  st_q <= S_RHIGH;
               end
            end
            S_RHIGH: begin
               if (tmr_q == 3'd0) begin
                  if (cnt_q != 13'd1) begin
                     cnt_q <= cnt_q - 13'd1;
                     read_strobe_n_q <= 1'b0;
                     tmr_q <= HALF;
                     st_q <= S_RLOW;
                  end else begin
                     st_q <= S_IDLE;
                  end
               end
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: include/nbc_regs.vh
`ifndef NBC_REGS_VH
`define NBC_REGS_VH
// Command codes
`define NBC_CMD_READ1 8'h00
`define NBC_CMD_READ2 8'h30
`define NBC_CMD_RND_OUT1 8'h05
`define NBC_CMD_RND_OUT2 8'he0
`define NBC_CMD_STATUS 8'h70
`define NBC_CMD_PSTATUS 8'hf1
`define NBC_CMD_RESET 8'hff
`define NBC_CMD_PROG1 8'h80
`define NBC_CMD_PROG2 8'h10
`define NBC_CMD_CACHE_PROG 8'h15
`define NBC_CMD_RND_IN 8'h85
`define NBC_CMD_DUMMY_PROG 8'h11
`define NBC_CMD_PROG_PLANE2 8'h81
`define NBC_CMD_PLANE_SETUP 8'h60
`define NBC_CMD_COPY_READ 8'h35
`define NBC_CMD_CACHE_START 8'h33
`define NBC_CMD_CACHE_NEXT 8'h31
`define NBC_CMD_CACHE_END 8'h3f
`define NBC_CMD_ERASE2 8'hd0
// Address layout and status ready bit
`define NBC_ADDR_CYCLES 3'd5
`define NBC_COL_BITS 13
`define NBC_ROW_BITS 19
`define NBC_PLANE_BIT 7
`define NBC_STAT_READY_BIT 6
// Timing
`define NBC_CYCLE_NS 8
`define NBC_RE_PERIOD_NS 25
`define NBC_STBY_US 10
`define NBC_LOAD_US 60
`endif

// File: bench/nbc_host_checker.sv
`timescale 1ns/100ps
`default_nettype none
module nbc_chk #(parameter STBY_CYC = 20, LOAD_CYC = 50) (
   input wire logic clk, nrst, cs_n_q, cle_q, ale_q, // Clock, pins
   input wire logic write_strobe_n_q, read_strobe_n_q, // Strobes
   input wire logic modify_lock_n_q, shared_io_bus_oe_q, // Lock, drive
   input wire logic ready_busy_n, device_ready, standby_q, // Status
   input wire logic load_timeout_q, rdata_valid_q // Flags
);
   int hi_q, bz_q;
   // Counting here, not in the design, keeps the check independent
   always @(posedge clk) begin
      hi_q <= (!nrst || !cs_n_q) ? 0 : hi_q + 1;
      bz_q <= (!nrst || ready_busy_n) ? 0 : bz_q + 1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   cmd_cycle_a: assert property ($rose(write_strobe_n_q) &&
      cle_q |-> !ale_q && !cs_n_q && read_strobe_n_q)
      else $error("bad command cycle");
   addr_cycle_a: assert property ($rose(write_strobe_n_q) &&
      ale_q |-> !cle_q && !cs_n_q && read_strobe_n_q)
      else $error("bad address cycle");
   data_in_a: assert property ($rose(write_strobe_n_q) && !cle_q &&
      !ale_q |-> !cs_n_q && read_strobe_n_q && modify_lock_n_q)
      else $error("bad data in cycle");
   data_out_a: assert property (!read_strobe_n_q |->
      write_strobe_n_q && !cle_q && !ale_q && !cs_n_q && !shared_io_bus_oe_q)
      else $error("bad data out cycle");
   re_width_a: assert property ($fell(read_strobe_n_q) |->
      !read_strobe_n_q[*3] ##1 read_strobe_n_q) else $error("bad read pulse");
   we_width_a: assert property ($fell(write_strobe_n_q) |->
      !write_strobe_n_q[*3] ##1 write_strobe_n_q) else $error("bad write pulse");
   // Flag clears one cycle after select drops, so look at the prior cycle
   standby_wait_a: assert property (standby_q |->
      $past(cs_n_q) && hi_q >= STBY_CYC) else $error("early standby");
   stby_entry_a: assert property (hi_q >= STBY_CYC |-> standby_q)
      else $error("standby missed");
   load_flag_a: assert property (bz_q > LOAD_CYC |->
      load_timeout_q) else $error("load timeout missed");
   load_tmo_a: assert property ($rose(load_timeout_q) |->
      bz_q >= LOAD_CYC - 1) else $error("early load timeout");
   rd_valid_a: assert property (rdata_valid_q |->
      $rose(read_strobe_n_q)) else $error("stray read valid");
   cover property (rdata_valid_q);
   cover property ($rose(standby_q));
   cover property ($rose(load_timeout_q));
endmodule
bind nbc_host nbc_chk #(.STBY_CYC(STBY_CYC), .LOAD_CYC(LOAD_CYC)) chk (.*);
`default_nettype wire

// File: bench/nbc_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module nbc_flash_model (
   input wire logic cs_n, cle, ale, we_n, re_n, lock_n, slow, // Pins
   input wire logic [7:0] io_i, // Bus level
   output logic [7:0] io_o, // Inverted last byte when released
   output logic rb_n // Low while busy
);
   logic [7:0] ab [1:5], pg, last, wlast;
   logic [12:0] col;
   logic stat;
   int k, wcnt;
   initial begin
      rb_n = 1;
      stat = 0;
      last = 0;
      k = 1;
      wcnt = 0;
   end
   always @(posedge we_n) if (!cs_n) begin
      if (cle) begin
         if (rb_n || io_i == 8'h70 || io_i == 8'hf1 || io_i == 8'hff) begin
            k = 1;
            stat = io_i == 8'h70 || io_i == 8'hf1 ||
               (stat && io_i != 8'h00);
            if (io_i == 8'h30 || io_i == 8'he0)
               col = {ab[2][4:0], ab[1]};
            if (io_i == 8'h30) begin
               pg = ab[3];
               rb_n = 0;
               // Load runs on with select high
               rb_n <= #(slow ? 600 : 200) 1'b1;
            end
         end
      end else if (ale) begin
         if (k <= 5) ab[k] = io_i;
         k++;
      end else if (lock_n) begin
         wlast = io_i;
         wcnt++;
      end
   end
   always @(negedge re_n) if (!cs_n) begin
      last = stat ? {1'b0, rb_n, 6'h0} : col[7:0] ^ pg;
      if (!stat) col++;
   end
   assign io_o = (!cs_n && !re_n) ? last : ~last;
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
   $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb_top;
   localparam int SC = 20, LC = 50;
   localparam logic [31:0] AD = 32'hffb4_e3a7;
   logic clk = 0, nrst = 0, ce = 1, cmd_valid = 0, cmd_write = 0;
   logic cmd_modify = 0, slow = 0, to_seen = 0;
   logic [1:0] cmd_op = 0;
   logic [7:0] cmd_code = 0, wdata = 0, rdata_q, shared_io_bus_o_q, dev_o;
   logic [7:0] shared_io_bus_i;
   logic [31:0] cmd_addr = 0;
   logic [12:0] cmd_len = 0;
   wire cmd_ready, wdata_take, rdata_valid_q, cs_n_q, cle_q, ale_q;
   wire write_strobe_n_q, read_strobe_n_q, modify_lock_n_q, standby_q;
   wire shared_io_bus_oe_q, ready_busy_n, device_ready, load_timeout_q;
   int error_cnt = 0, tests_run = 0;
   logic [7:0] rq [$];
   nbc_host #(.STBY_CYC(SC), .LOAD_CYC(LC)) uut (.*);
   nbc_flash_model dev (.cs_n(cs_n_q), .cle(cle_q), .ale(ale_q),
      .we_n(write_strobe_n_q), .re_n(read_strobe_n_q), .slow(slow),
      .lock_n(modify_lock_n_q), .io_i(shared_io_bus_i), .io_o(dev_o),
      .rb_n(ready_busy_n));
   assign shared_io_bus_i = shared_io_bus_oe_q ? shared_io_bus_o_q : dev_o;
   initial forever #4 clk = ~clk;
   always @(posedge clk) begin
      if (rdata_valid_q) rq.push_back(rdata_q);
      if (wdata_take) wdata <= wdata + 8'h11;
      if (load_timeout_q) to_seen <= 1;
   end
   task automatic op(input [1:0] o, input [7:0] c, input [31:0] a,
      input [12:0] n, input w, m);
      int t;
      cmd_op <= o;
      cmd_code <= c;
      cmd_addr <= a;
      cmd_len <= n;
      cmd_write <= w;
      cmd_modify <= m;
      cmd_valid <= 1;
      @(posedge clk);
      while (!cmd_ready) @(posedge clk);
      cmd_valid <= 0;
      @(posedge clk);
      for (t = 0; t < 999 && !cmd_ready; t++) @(posedge clk);
      if (!cmd_ready) error_cnt++;
   endtask
   task automatic page_read;
      int t;
      op(0, 8'h00, 0, 0, 0, 0);
      op(1, 0, AD, 0, 0, 0);
      op(0, 8'h30, 0, 0, 0, 0);
      `CHK(device_ready, 1'b0)
      for (t = 0; t < 999 && !device_ready; t++) @(posedge clk);
      if (!device_ready) error_cnt++;
   endtask
   task automatic t_read;
      int i;
      page_read;
      `CHK(dev.ab[1], AD[7:0])
      `CHK(dev.ab[2], {3'h0, AD[12:8]})
      `CHK(dev.ab[3], AD[20:13])
      `CHK(dev.ab[5], {5'h0, AD[31:29]})
      rq = {};
      op(3, 0, 0, 3, 0, 0);
      `CHK(rq.size(), 3)
      for (i = 0; i < 3; i++)
         `CHK(rq[i], (AD[7:0] + 8'(i)) ^ AD[20:13])
      `CHK(to_seen, 1'b0)
   endtask
   task automatic t_rnd;
      int i;
      op(0, 8'h05, 0, 0, 0, 0);
      op(2, 0, 32'h1ffe, 0, 0, 0);
      op(0, 8'he0, 0, 0, 0, 0);
      rq = {};
      op(3, 0, 0, 2, 0, 0);
      for (i = 0; i < 2; i++)
         `CHK(rq[i], (8'hfe + 8'(i)) ^ AD[20:13])
   endtask
   task automatic t_stat;
      op(0, 8'h70, 0, 0, 0, 0);
      rq = {};
      op(3, 0, 0, 1, 0, 0);
      `CHK(rq[0][6], 1'b1)
      slow <= 1;
      page_read;
      `CHK(to_seen, 1'b1)
   endtask
   task automatic t_prog;
      op(0, 8'h80, 0, 0, 0, 1);
      op(1, 0, AD, 0, 0, 1);
      op(3, 0, 0, 2, 1, 1);
      op(0, 8'h10, 0, 0, 0, 1);
      `CHK(dev.wcnt, 2)
      `CHK(dev.wlast, 8'h11)
   endtask
   task automatic t_stby;
      repeat (SC + 5) @(posedge clk);
      `CHK(standby_q, 1'b1)
   endtask
   // A request while frozen must not start a bus cycle
   task automatic t_ce;
      ce <= 0;
      op(0, 8'h70, 0, 0, 0, 0);
      repeat (3) @(posedge clk);
      `CHK(cs_n_q, 1'b1)
      ce <= 1;
   endtask
   task stop_test;
      if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1;
      t_read;
      t_rnd;
      t_stat;
      t_prog;
      t_stby;
      t_ce;
      stop_test;
   end
   initial begin
      #200000;
      error_cnt++;
      stop_test;
   end
endmodule
`default_nettype wire
